/* File: cpu_move_logic_return_ops.sv */
// Execution unit for increment, OR, moves, literal load, rotate, no-op and returns
`timescale 1ns/100ps
module cpu_move_logic_return_ops (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cx_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic global_interrupt_enable
);
  cx_pkg::state_type state_r, state_nxt;
  cx_pkg::instr_type instr_r, instr_nxt, wr_instr;
  logic [1:0] div_r, div_nxt;
  logic [1:0] left_r, left_nxt;
  logic [7:0] w_r, w_nxt;
  logic z_r, z_nxt;
  logic c_r, c_nxt;
  logic gie_r, gie_nxt;
  logic [cx_pkg::PC_W-1:0] pc_r, pc_nxt;
  logic [cx_pkg::PC_W-1:0] stack_top_r, stack_top_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic err_r, err_nxt;
  logic [7:0] file_mem [cx_pkg::FILE_DEPTH];
  logic mem_we;
  logic [cx_pkg::FADDR_W-1:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] fval;
  logic [7:0] res;
  logic busy, tick, commit;
  logic setup, access, wr_ok, file_hit;

  assign busy = (state_r == cx_pkg::ST_EXEC);
  assign tick = busy && (div_r == cx_pkg::DIV_LAST);
  assign commit = tick && (left_r == cx_pkg::CYC_ONE);
  assign fval = file_mem[instr_r.faddr];
  assign wr_instr = cx_pkg::instr_type'(pwdata[cx_pkg::INSTR_W-1:0]);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_ok = access && pwrite && !err_r;
  assign file_hit = (paddr[11:9] == cx_pkg::FILE_PAGE);
  assign pready = access;
  assign pslverr = access && err_r;
  assign prdata = prdata_r;
  assign global_interrupt_enable = gie_r;

  // Sequencer: one write to the instruction register runs one instruction
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    div_nxt = div_r;
    left_nxt = left_r;
    if (!busy) begin
      div_nxt = cx_pkg::DIV_ZERO;
      if (wr_ok && paddr == cx_pkg::OFS_INSTR) begin
        state_nxt = cx_pkg::ST_EXEC;
        instr_nxt = wr_instr;
        if (wr_instr.op == cx_pkg::OP_RETURN_WITH_LITERAL ||
            wr_instr.op == cx_pkg::OP_RETURN_FROM_INTERRUPT) begin
          left_nxt = cx_pkg::CYC_TWO;
        end else begin
          left_nxt = cx_pkg::CYC_ONE;
        end
      end
    end else begin
      div_nxt = div_r + 2'h1;
      if (tick) begin
        left_nxt = left_r - 2'h1;
        if (commit) begin
          state_nxt = cx_pkg::ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cx_pkg::ST_IDLE;
      instr_r <= '0;
      div_r <= cx_pkg::DIV_ZERO;
      left_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      div_r <= div_nxt;
      left_r <= left_nxt;
    end
  end

  // Datapath and architectural state
  always_comb begin
    w_nxt = w_r;
    z_nxt = z_r;
    c_nxt = c_r;
    gie_nxt = gie_r;
    pc_nxt = pc_r;
    stack_top_nxt = stack_top_r;
    mem_we = 1'b0;
    mem_addr = instr_r.faddr;
    res = fval;
    case (instr_r.op)
      cx_pkg::OP_INCREMENT_FILE: res = fval + cx_pkg::ONE_BYTE;
      cx_pkg::OP_OR_WORKING_WITH_FILE: res = fval | w_r;
      cx_pkg::OP_ROTATE_LEFT_CARRY: res = {fval[6:0], c_r};
      cx_pkg::OP_STORE_WORKING_TO_FILE: res = w_r;
      cx_pkg::OP_LOAD_LITERAL_WORKING: res = instr_r.lit;
      cx_pkg::OP_RETURN_WITH_LITERAL: res = instr_r.lit;
      default: res = fval;
    endcase
    mem_wdata = res;
    if (commit) begin
      pc_nxt = pc_r + cx_pkg::PC_STEP;
      case (instr_r.op)
        cx_pkg::OP_INCREMENT_FILE, cx_pkg::OP_OR_WORKING_WITH_FILE,
        cx_pkg::OP_MOVE_FILE: begin
          z_nxt = (res == cx_pkg::ZERO_BYTE);
          if (instr_r.dest == cx_pkg::DEST_WORK) begin
            w_nxt = res;
          end else begin
            mem_we = 1'b1;
          end
        end
        cx_pkg::OP_ROTATE_LEFT_CARRY: begin
          c_nxt = fval[7];
          if (instr_r.dest == cx_pkg::DEST_WORK) begin
            w_nxt = res;
          end else begin
            mem_we = 1'b1;
          end
        end
        cx_pkg::OP_LOAD_LITERAL_WORKING: w_nxt = res;
        cx_pkg::OP_STORE_WORKING_TO_FILE: mem_we = 1'b1;
        cx_pkg::OP_RETURN_FROM_INTERRUPT: begin
          pc_nxt = stack_top_r;
          gie_nxt = 1'b1;
        end
        cx_pkg::OP_RETURN_WITH_LITERAL: begin
          w_nxt = res;
          pc_nxt = stack_top_r;
        end
        default: pc_nxt = pc_r + cx_pkg::PC_STEP;
      endcase
    end else if (wr_ok) begin
      // Only reachable while idle: busy writes were refused at setup
      if (file_hit) begin
        mem_we = 1'b1;
        mem_addr = paddr[8:2];
        mem_wdata = pwdata[7:0];
      end
      case (paddr)
        cx_pkg::OFS_WORK: w_nxt = pwdata[7:0];
        cx_pkg::OFS_STATUS: begin
          z_nxt = pwdata[cx_pkg::ST_Z_BIT];
          c_nxt = pwdata[cx_pkg::ST_C_BIT];
          gie_nxt = pwdata[cx_pkg::ST_GIE_BIT];
        end
        cx_pkg::OFS_PC: pc_nxt = pwdata[cx_pkg::PC_W-1:0];
        cx_pkg::OFS_STACK_TOP: stack_top_nxt = pwdata[cx_pkg::PC_W-1:0];
        default: w_nxt = w_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_r <= cx_pkg::WORK_RESET;
      z_r <= 1'b0;
      c_r <= 1'b0;
      gie_r <= 1'b0;
      pc_r <= cx_pkg::PC_RESET;
      stack_top_r <= cx_pkg::PC_RESET;
    end else begin
      w_r <= w_nxt;
      z_r <= z_nxt;
      c_r <= c_nxt;
      gie_r <= gie_nxt;
      pc_r <= pc_nxt;
      stack_top_r <= stack_top_nxt;
    end
  end

  // File array has no reset; contents are software's to set up
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      file_mem[mem_addr] <= mem_wdata;
    end
  end

  // Bus slave: decode at setup so read data comes from a flop
  always_comb begin
    prdata_nxt = prdata_r;
    err_nxt = err_r;
    if (setup) begin
      err_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (file_hit) begin
        prdata_nxt[7:0] = file_mem[paddr[8:2]];
        err_nxt = (paddr[1:0] != 2'h0) || (pwrite && busy);
      end else begin
        case (paddr)
          cx_pkg::OFS_INSTR: begin
            prdata_nxt[cx_pkg::INSTR_W-1:0] = instr_r;
            err_nxt = pwrite && (busy || wr_instr.op > cx_pkg::OP_LAST);
          end
          cx_pkg::OFS_WORK: begin
            prdata_nxt[7:0] = w_r;
            err_nxt = pwrite && busy;
          end
          cx_pkg::OFS_STATUS: begin
            prdata_nxt[cx_pkg::ST_Z_BIT] = z_r;
            prdata_nxt[cx_pkg::ST_C_BIT] = c_r;
            prdata_nxt[cx_pkg::ST_GIE_BIT] = gie_r;
            prdata_nxt[cx_pkg::ST_BUSY_BIT] = busy;
            err_nxt = pwrite && busy;
          end
          cx_pkg::OFS_PC: begin
            prdata_nxt[cx_pkg::PC_W-1:0] = pc_r;
            err_nxt = pwrite && busy;
          end
          cx_pkg::OFS_STACK_TOP: begin
            prdata_nxt[cx_pkg::PC_W-1:0] = stack_top_r;
            err_nxt = pwrite && busy;
          end
          default: err_nxt = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      err_r <= err_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic start;
  assign start = !busy && wr_ok && paddr == cx_pkg::OFS_INSTR;

  sequence s_busy_one;
    busy [*4] ##1 !busy;
  endsequence
  sequence s_busy_two;
    busy [*8] ##1 !busy;
  endsequence

  a_incr_result: assert property (
    commit && instr_r.op == cx_pkg::OP_INCREMENT_FILE && instr_r.dest == cx_pkg::DEST_WORK
    |=> w_r == 8'($past(fval) + cx_pkg::ONE_BYTE))
    else $error("increment result wrong");
  a_or_result: assert property (
    commit && instr_r.op == cx_pkg::OP_OR_WORKING_WITH_FILE && instr_r.dest == cx_pkg::DEST_WORK
    |=> w_r == ($past(fval) | $past(w_r)))
    else $error("or result wrong");
  a_move_file: assert property (
    commit && instr_r.op == cx_pkg::OP_MOVE_FILE |=> $stable(fval)
    && (w_r == (($past(instr_r.dest) == cx_pkg::DEST_WORK) ? $past(fval) : $past(w_r))))
    else $error("move file wrong");
  a_move_zero: assert property (
    commit && instr_r.op == cx_pkg::OP_MOVE_FILE |=> z_r == ($past(fval) == cx_pkg::ZERO_BYTE))
    else $error("zero flag wrong after move");
  a_literal_flags: assert property (
    commit && instr_r.op == cx_pkg::OP_LOAD_LITERAL_WORKING
    |=> w_r == $past(instr_r.lit) && $stable(z_r) && $stable(c_r))
    else $error("literal load wrong");
  a_store_file: assert property (
    commit && instr_r.op == cx_pkg::OP_STORE_WORKING_TO_FILE
    |=> fval == $past(w_r) && $stable(z_r) && $stable(c_r))
    else $error("store working wrong");
  a_intr_return: assert property (
    commit && instr_r.op == cx_pkg::OP_RETURN_FROM_INTERRUPT
    |=> gie_r && pc_r == $past(stack_top_r) && $stable(z_r))
    else $error("interrupt return wrong");
  a_literal_return: assert property (
    commit && instr_r.op == cx_pkg::OP_RETURN_WITH_LITERAL
    |=> w_r == $past(instr_r.lit) && pc_r == $past(stack_top_r))
    else $error("literal return wrong");
  a_return_two: assert property (
    start && wr_instr.op == cx_pkg::OP_RETURN_WITH_LITERAL |=> s_busy_two)
    else $error("literal return not two cycles");
  a_rotate_carry: assert property (
    commit && instr_r.op == cx_pkg::OP_ROTATE_LEFT_CARRY
    |=> c_r == $past(fval[7]) && $stable(z_r)
    && ((($past(instr_r.dest) == cx_pkg::DEST_WORK) ? w_r : fval)
    == {$past(fval[6:0]), $past(c_r)}))
    else $error("rotate through carry wrong");
  a_nop_one: assert property (
    start && wr_instr.op == cx_pkg::OP_NOP |=> s_busy_one ##0 $stable(w_r) && $stable(z_r))
    else $error("no-op not one quiet cycle");
endmodule

/* File: cx_pkg.sv */
// Constants, register map and types of the move, logic and return execution unit
package cx_pkg;
  localparam int unsigned AW = 12;
  localparam logic [AW-1:0] OFS_INSTR = 12'h000;
  localparam logic [AW-1:0] OFS_WORK = 12'h004;
  localparam logic [AW-1:0] OFS_STATUS = 12'h008;
  localparam logic [AW-1:0] OFS_PC = 12'h00C;
  localparam logic [AW-1:0] OFS_STACK_TOP = 12'h010;
  // File words sit at 0x200 + 4*f
  localparam logic [2:0] FILE_PAGE = 3'h1;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PC_W = 13;
  localparam int unsigned INSTR_W = 20;
  localparam int unsigned ST_Z_BIT = 0;
  localparam int unsigned ST_C_BIT = 1;
  localparam int unsigned ST_GIE_BIT = 2;
  localparam int unsigned ST_BUSY_BIT = 3;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic DEST_WORK = 1'b0;
  // Instruction cycle is four core clocks
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned INSTR_CYCLE_NS = 32;
  localparam int unsigned CLKS_PER_CYCLE = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] DIV_LAST = 2'(CLKS_PER_CYCLE - 1);
  localparam logic [1:0] DIV_ZERO = 2'h0;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_INCREMENT_FILE = 4'h1;
  localparam logic [3:0] OP_OR_WORKING_WITH_FILE = 4'h2;
  localparam logic [3:0] OP_MOVE_FILE = 4'h3;
  localparam logic [3:0] OP_LOAD_LITERAL_WORKING = 4'h4;
  localparam logic [3:0] OP_STORE_WORKING_TO_FILE = 4'h5;
  localparam logic [3:0] OP_RETURN_FROM_INTERRUPT = 4'h6;
  localparam logic [3:0] OP_RETURN_WITH_LITERAL = 4'h7;
  localparam logic [3:0] OP_ROTATE_LEFT_CARRY = 4'h8;
  localparam logic [3:0] OP_LAST = 4'h8;
  typedef struct packed {
    logic [3:0] op;
    logic dest;
    logic [FADDR_W-1:0] faddr;
    logic [7:0] lit;
  } instr_type;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} state_type;
endpackage

/* File: tb_top.sv */
// Self-checking testbench for the move, logic and return execution unit
`timescale 1ns/100ps
module tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [cx_pkg::AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic global_interrupt_enable;
  int errors;
  int n_checks;
  int cycles;
  logic [12:0] pc_exp;
  logic [12:0] stack_exp;

  cpu_move_logic_return_ops DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .global_interrupt_enable(global_interrupt_enable));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Idle gap cycles place the setup edge exactly, for busy-window probing
  task automatic apb(input logic wr, input logic [cx_pkg::AW-1:0] a, input logic [31:0] d,
                     input int gap, output logic [31:0] r, output logic e);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [cx_pkg::AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 0, r, e);
  endtask

  task automatic rchk(input string name, input logic [cx_pkg::AW-1:0] a,
                      input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, 0, r, e);
    chk(name, r, exp);
  endtask

  function automatic logic [cx_pkg::AW-1:0] fa(input logic [6:0] f);
    return {cx_pkg::FILE_PAGE, f, 2'b00};
  endfunction

  function automatic logic [31:0] st(input logic g, input logic c, input logic z);
    return {29'h0000_0000, g, c, z};
  endfunction

  task automatic exec(input logic [3:0] op, input logic d, input logic [6:0] f,
                      input logic [7:0] k);
    cx_pkg::instr_type i;
    logic [31:0] r;
    logic e;
    logic ret;
    i.op = op;
    i.dest = d;
    i.faddr = f;
    i.lit = k;
    ret = (op == cx_pkg::OP_RETURN_FROM_INTERRUPT) || (op == cx_pkg::OP_RETURN_WITH_LITERAL);
    apb(1'b1, cx_pkg::OFS_INSTR, {12'h000, i}, 0, r, e);
    apb(1'b0, cx_pkg::OFS_STATUS, 32'h0000_0000, ret ? 4 : 0, r, e);
    chk("busy_during", {31'h0, r[3]}, 32'h0000_0001);
    apb(1'b0, cx_pkg::OFS_STATUS, 32'h0000_0000, 1, r, e);
    chk("busy_after", {31'h0, r[3]}, 32'h0000_0000);
    pc_exp = ret ? stack_exp : pc_exp + 13'h0001;
    rchk("pc", cx_pkg::OFS_PC, {19'h0, pc_exp});
  endtask

  task automatic t_reset();
    chk("gie_pin", {31'h0, global_interrupt_enable}, 32'h0000_0000);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_0000);
    rchk("status", cx_pkg::OFS_STATUS, st(0, 0, 0));
  endtask

  task automatic t_literal_store();
    wr(cx_pkg::OFS_STATUS, st(0, 1, 1));
    wr(fa(7'h00), 32'h0000_0011);
    exec(cx_pkg::OP_LOAD_LITERAL_WORKING, 1'b1, 7'h00, 8'hA5);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_00A5);
    rchk("status", cx_pkg::OFS_STATUS, st(0, 1, 1));
    exec(cx_pkg::OP_STORE_WORKING_TO_FILE, 1'b0, 7'h7F, 8'h00);
    rchk("file127", fa(7'h7F), 32'h0000_00A5);
    rchk("file0", fa(7'h00), 32'h0000_0011);
    rchk("status", cx_pkg::OFS_STATUS, st(0, 1, 1));
  endtask

  task automatic t_incr_or();
    wr(fa(7'h05), 32'h0000_00FF);
    exec(cx_pkg::OP_INCREMENT_FILE, 1'b1, 7'h05, 8'h00);
    rchk("file5", fa(7'h05), 32'h0000_0000);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_00A5);
    exec(cx_pkg::OP_INCREMENT_FILE, 1'b0, 7'h05, 8'h00);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_0001);
    rchk("file5", fa(7'h05), 32'h0000_0000);
    wr(fa(7'h06), 32'h0000_0030);
    exec(cx_pkg::OP_OR_WORKING_WITH_FILE, 1'b1, 7'h06, 8'h00);
    rchk("file6", fa(7'h06), 32'h0000_0031);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_0001);
    exec(cx_pkg::OP_OR_WORKING_WITH_FILE, 1'b0, 7'h06, 8'h00);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_0031);
  endtask

  task automatic t_move();
    exec(cx_pkg::OP_MOVE_FILE, 1'b1, 7'h05, 8'h00);
    rchk("file5", fa(7'h05), 32'h0000_0000);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_0031);
    rchk("status", cx_pkg::OFS_STATUS, st(0, 1, 1));
    exec(cx_pkg::OP_MOVE_FILE, 1'b0, 7'h00, 8'h00);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_0011);
    rchk("status", cx_pkg::OFS_STATUS, st(0, 1, 0));
  endtask

  task automatic t_rotate();
    wr(fa(7'h07), 32'h0000_0081);
    exec(cx_pkg::OP_ROTATE_LEFT_CARRY, 1'b1, 7'h07, 8'h00);
    rchk("file7", fa(7'h07), 32'h0000_0003);
    rchk("status", cx_pkg::OFS_STATUS, st(0, 1, 0));
    exec(cx_pkg::OP_ROTATE_LEFT_CARRY, 1'b0, 7'h07, 8'h00);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_0007);
    rchk("status", cx_pkg::OFS_STATUS, st(0, 0, 0));
  endtask

  task automatic t_returns();
    logic [31:0] r;
    logic e;
    stack_exp = 13'h1ABC;
    wr(cx_pkg::OFS_STACK_TOP, {19'h0, stack_exp});
    exec(cx_pkg::OP_RETURN_WITH_LITERAL, 1'b0, 7'h00, 8'h5A);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_005A);
    exec(cx_pkg::OP_RETURN_FROM_INTERRUPT, 1'b0, 7'h00, 8'h00);
    chk("gie_pin", {31'h0, global_interrupt_enable}, 32'h0000_0001);
    rchk("status", cx_pkg::OFS_STATUS, st(1, 0, 0));
    exec(cx_pkg::OP_NOP, 1'b1, 7'h07, 8'hFF);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_005A);
    rchk("status", cx_pkg::OFS_STATUS, st(1, 0, 0));
    rchk("file7", fa(7'h07), 32'h0000_0003);
    // Past the last file word the map ends
    apb(1'b0, 12'h400, 32'h0000_0000, 0, r, e);
    chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
  endtask

  // Refused writes must leave every register as it was
  task automatic t_refused();
    logic [31:0] r;
    logic e;
    apb(1'b1, cx_pkg::OFS_INSTR, 32'h0000_0000, 0, r, e);
    apb(1'b1, cx_pkg::OFS_WORK, 32'h0000_00EE, 0, r, e);
    chk("busy_write_err", {31'h0, e}, 32'h0000_0001);
    rchk("w", cx_pkg::OFS_WORK, 32'h0000_005A);
    pc_exp = pc_exp + 13'h0001;
    rchk("pc", cx_pkg::OFS_PC, {19'h0, pc_exp});
    apb(1'b1, cx_pkg::OFS_INSTR, 32'h000F_0000, 0, r, e);
    chk("bad_op_err", {31'h0, e}, 32'h0000_0001);
    rchk("status", cx_pkg::OFS_STATUS, st(1, 0, 0));
    apb(1'b1, fa(7'h07) | 12'h001, 32'h0000_00EE, 0, r, e);
    chk("misaligned_err", {31'h0, e}, 32'h0000_0001);
    rchk("file7", fa(7'h07), 32'h0000_0003);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    errors = 0;
    n_checks = 0;
    cycles = 0;
    pc_exp = 13'h0000;
    stack_exp = 13'h0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_literal_store();
    t_incr_or();
    t_move();
    t_rotate();
    t_returns();
    t_refused();
    end_of_test();
  end
endmodule
